// file: core/wupc_ctrl.sv
// wupc_ctrl: warm-up speed state controller for one mechanism
// assumes nrst marks controller power-on, cfg is the stored parameter set,
// and off_stop_sec is the stop time carried across power-off by the host
`timescale 1ns/1ps
`default_nettype none
module wupc_ctrl
	import wupc_pkg::*;
#(
	parameter int unsigned NJ = 8,
	parameter int unsigned TICK_CYC = TICK_CYCLES
) (
	input wire logic clk,
	input wire logic nrst,
	input wire wupc_cfg_t cfg,
	input wire logic [NJ-1:0] joint_moving,
	input wire logic was_cancelled,
	input wire logic [SEC_W-1:0] off_stop_sec,
	input wire logic mech_warmup_enable_io,
	input wire logic io_right,
	input wire logic motion_busy,
	input wire logic panel_ovr_view,
	output logic mech_warmup_enable_out,
	output logic mech_warmup_active_out,
	output logic panel_underscore,
	output wupc_stat_t stat
);
	initial begin
		if (NJ < 1 || NJ > 8) begin
			$error("NJ must be 1 to 8");
		end
		if (TICK_CYC < 1) begin
			$error("TICK_CYC must be at least one");
		end
		// the counters and remaining times must hold the longest resume time
		if (int'(RESUME_MAX) * SEC_PER_MIN >= (1 << SEC_W)) begin
			$error("SEC_W too narrow for the resume time");
		end
		if (OVR_MIN >= OVR_FULL) begin
			$error("override floor must lie below full speed");
		end
		if (HOLD_RATIO_MAX > 7'h64) begin
			$error("hold ratio beyond the valid time");
		end
	end

	// ==========================================================
	// state
	typedef enum logic [2:0] {
		ST_OFF = 3'b001,
		ST_WARM = 3'b010,
		ST_NORM = 3'b100
	} wupc_state_t;

	wupc_state_t state_q;
	logic boot_q;
	logic param_en_q;
	logic live_en_q;
	logic en_io_q;
	logic tick;
	logic [NJ-1:0] mask;
	logic [NJ-1:0] clr_run;
	logic [SEC_W-1:0] run_s [NJ];
	logic [SEC_W-1:0] stop_s [NJ];
	logic [SEC_W-1:0] valid_sec;
	logic [SEC_W-1:0] resume_sec;
	logic [SEC_W-1:0] min_run;
	logic [SEC_W-1:0] max_stop;
	logic all_run_done;
	logic any_stop_over;
	logic [6:0] init_ovr;
	logic [5:0] valid_min;
	logic [10:0] resume_min;
	logic [5:0] hold_ratio;
	logic cfg_ok;
	logic en_rise;
	logic io_accept;
	logic [6:0] ovr_d;

	// ==========================================================
	// clamped configuration
	// out-of-range limits are clamped, but an empty mask, a zero valid time or a full initial override disables the block
	// joint mask order
	assign mask = cfg.target_joint_mask[NJ-1:0];
	assign valid_min = (cfg.valid_min > VALID_MAX) ? VALID_MAX : cfg.valid_min;
	assign resume_min = (cfg.resume_min < RESUME_MIN) ? RESUME_MIN :
		((cfg.resume_min > RESUME_MAX) ? RESUME_MAX : cfg.resume_min);
	assign init_ovr = (cfg.init_ovr < OVR_MIN) ? OVR_MIN :
		((cfg.init_ovr > OVR_FULL) ? OVR_FULL : cfg.init_ovr);
	assign hold_ratio = (cfg.hold_ratio > HOLD_RATIO_MAX) ? HOLD_RATIO_MAX : cfg.hold_ratio;
	assign valid_sec = SEC_W'(valid_min * SEC_PER_MIN);
	assign resume_sec = SEC_W'(resume_min * SEC_PER_MIN);
	assign cfg_ok = (mask != '0) && (valid_min != '0) && (init_ovr != OVR_FULL);

	// ==========================================================
	// time base and joint counters
	// clock derived time base
	wupc_tick #(
		.CYCLES(TICK_CYC)
	) u_tick (
		.clk(clk),
		.nrst(nrst),
		.tick(tick)
	);

	genvar gj;
	generate
		for (gj = 0; gj < NJ; gj++) begin : g_joint
			wupc_joint_timer u_jt (
				.clk(clk),
				.nrst(nrst),
				.tick(tick),
				.moving(joint_moving[gj]),
				.clr_run(clr_run[gj]),
				.run_q(run_s[gj]),
				.stop_q(stop_s[gj])
			);
		end
	endgenerate

	// run time is restarted for every joint when warm-up is entered
	always_comb begin
		clr_run = '0;
		if (state_q != ST_WARM) begin
			clr_run = '1;
		end
	end

	always_comb begin
		min_run = '1;
		max_stop = '0;
		all_run_done = 1'b1;
		any_stop_over = 1'b0;
		for (int j = 0; j < NJ; j++) begin
			if (mask[j]) begin
				if (run_s[j] < min_run) begin
					min_run = run_s[j];
				end
				if (stop_s[j] > max_stop) begin
					max_stop = stop_s[j];
				end
				if (!(run_s[j] > valid_sec)) begin
					all_run_done = 1'b0;
				end
				if (stop_s[j] > resume_sec) begin
					any_stop_over = 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// enable handling
	// later writes of the stored enable wait for the next power-on
	// latch at power-on
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			boot_q <= 1'b1;
		end else begin
			boot_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			param_en_q <= 1'b0;
		end else if (boot_q) begin
			param_en_q <= cfg.warmup_enable_param;
		end
	end

	assign io_accept = io_right && !motion_busy && param_en_q && cfg_ok;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			live_en_q <= 1'b0;
		end else if (boot_q) begin
			live_en_q <= cfg.warmup_enable_param;
		end else if (io_accept) begin
			live_en_q <= mech_warmup_enable_io;
		end
	end

	// one-cycle pulse marking a take from disabled to enabled
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			en_io_q <= 1'b0;
		end else begin
			en_io_q <= io_accept && mech_warmup_enable_io && !live_en_q;
		end
	end
	assign en_rise = en_io_q;

	// ==========================================================
	// state machine
	// nothing leaves OFF until boot_q has let the stored enable settle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_OFF;
		end else if (!(param_en_q && live_en_q && cfg_ok) && !boot_q) begin
			state_q <= ST_OFF;
		end else begin
			unique case (state_q)
				ST_OFF: begin
					if (!boot_q && param_en_q && live_en_q && cfg_ok) begin
						if (was_cancelled && off_stop_sec < resume_sec && !en_rise) begin
							state_q <= ST_NORM;
						end else begin
							state_q <= ST_WARM;
						end
					end
				end
				ST_WARM: begin
					if (all_run_done) begin
						state_q <= ST_NORM;
					end
				end
				ST_NORM: begin
					if (any_stop_over || en_rise) begin
						state_q <= ST_WARM;
					end
				end
				default: begin
					state_q <= ST_OFF;
				end
			endcase
		end
	end

	// ==========================================================
	// override ramp: hold at initial value, then linear to full
	// ramp with least run time
	always_comb begin
		logic [SEC_W+7:0] hold_sec;
		logic [SEC_W+7:0] span;
		logic [SEC_W+7:0] past;
		logic [SEC_W+15:0] step;
		hold_sec = (SEC_W + 8)'((valid_sec * hold_ratio) / 100);
		span = (SEC_W + 8)'(valid_sec) - hold_sec;
		past = ((SEC_W + 8)'(min_run) > hold_sec) ? (SEC_W + 8)'(min_run) - hold_sec : '0;
		step = '0;
		ovr_d = OVR_FULL;
		if (state_q == ST_WARM) begin
			if (span != '0) begin
				step = (SEC_W + 16)'((past * (OVR_FULL - init_ovr)) / span);
			end
			// warm-up never reports full speed
			if ((SEC_W + 16)'(init_ovr) + step >= (SEC_W + 16)'(OVR_FULL)) begin
				ovr_d = OVR_FULL - 7'h01;
			end else begin
				ovr_d = init_ovr + step[6:0];
			end
		end
	end

	// ==========================================================
	// status
	// remaining times read zero where they do not apply
	// 100 in normal, below in warm-up
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stat <= '{OVR_FULL, '0, '0};
		end else begin
			stat.current_slowdown_value <= ovr_d;
			stat.remaining_run_time <= (state_q == ST_WARM && valid_sec >= min_run) ?
				valid_sec - min_run : '0;
			stat.remaining_stop_time <= (state_q == ST_NORM && resume_sec >= max_stop) ?
				resume_sec - max_stop : '0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mech_warmup_active_out <= 1'b0;
		end else begin
			mech_warmup_active_out <= (state_q == ST_WARM);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			panel_underscore <= 1'b0;
		end else begin
			panel_underscore <= (state_q == ST_WARM) && panel_ovr_view;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mech_warmup_enable_out <= 1'b0;
		end else begin
			mech_warmup_enable_out <= param_en_q && live_en_q && cfg_ok;
		end
	end
endmodule
`default_nettype wire

// file: core/wupc_pkg.sv
// wupc_pkg: constants and carrier types of the warm-up speed state controller
// assumes a single 125 MHz clock domain
package wupc_pkg;
	// ==========================================================
	// timing
	localparam int unsigned CLK_HZ = 125000000;
	localparam int unsigned SEC_PER_MIN = 60;
	// one-second time base, cycles derived from the clock rate
	localparam int unsigned TICK_SEC = 1;
	localparam int unsigned TICK_CYCLES = TICK_SEC * CLK_HZ;
	// ==========================================================
	// configuration limits and defaults
	localparam logic [6:0] OVR_FULL = 7'h64;
	localparam logic [6:0] OVR_MIN = 7'h32;
	localparam logic [6:0] OVR_INIT_DEF = 7'h46;
	localparam logic [5:0] VALID_MAX = 6'h3c;
	localparam logic [5:0] VALID_DEF = 6'h01;
	localparam logic [10:0] RESUME_MIN = 11'h001;
	localparam logic [10:0] RESUME_MAX = 11'h5a0;
	localparam logic [10:0] RESUME_DEF = 11'h03c;
	localparam logic [5:0] HOLD_RATIO_MAX = 6'h32;
	localparam logic [5:0] HOLD_RATIO_DEF = 6'h32;
	localparam int unsigned SEC_W = 17;
	// ==========================================================
	// stored parameters
	typedef struct packed {
		logic warmup_enable_param;
		logic [7:0] target_joint_mask;
		logic [5:0] valid_min;
		logic [10:0] resume_min;
		logic [6:0] init_ovr;
		logic [5:0] hold_ratio;
	} wupc_cfg_t;
	// reported status
	typedef struct packed {
		logic [6:0] current_slowdown_value;
		logic [SEC_W-1:0] remaining_run_time;
		logic [SEC_W-1:0] remaining_stop_time;
	} wupc_stat_t;
endpackage

// file: core/wupc_tick.sv
// wupc_tick: free running divider giving a one-cycle pulse per period
// assumes clk is the controller clock
`timescale 1ns/1ps
`default_nettype none
module wupc_tick #(
	parameter int unsigned CYCLES = 125000000
) (
	input wire logic clk,
	input wire logic nrst,
	output logic tick
);
	localparam int unsigned W = $clog2(CYCLES + 1);
	logic [W-1:0] cnt_q;
	initial begin
		if (CYCLES < 1) begin
			$error("CYCLES must be at least one");
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= '0;
		end else if (cnt_q == W'(CYCLES - 1)) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
	assign tick = (cnt_q == W'(CYCLES - 1));
endmodule
`default_nettype wire

// file: core/wupc_joint_timer.sv
// wupc_joint_timer: per-joint run and continuous stop second counters
// assumes tick is a one-cycle pulse once per second
`timescale 1ns/1ps
`default_nettype none
module wupc_joint_timer
	import wupc_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic tick,
	input wire logic moving,
	input wire logic clr_run,
	output logic [SEC_W-1:0] run_q,
	output logic [SEC_W-1:0] stop_q
);
	localparam logic [SEC_W-1:0] SAT = '1;
	// saturating, so a very long idle never wraps to a short one
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			run_q <= '0;
		end else if (clr_run) begin
			run_q <= '0;
		end else if (tick && moving && run_q != SAT) begin
			run_q <= run_q + 1'b1;
		end
	end
	// a joint counts as stopped whenever it is still, whatever the other joints do
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stop_q <= '0;
		end else if (moving) begin
			stop_q <= '0;
		end else if (tick && stop_q != SAT) begin
			stop_q <= stop_q + 1'b1;
		end
	end
endmodule
`default_nettype wire

// file: sim/wupc_io_host.sv
// wupc_io_host: external I/O controller model on the dedicated lines
// assumes bench requests change at the falling edge; model answers at the next falling edge
`timescale 1ns/1ps
`default_nettype none
module wupc_io_host (
	input wire logic clk,
	input wire logic want_right,
	input wire logic want_en,
	input wire logic want_busy,
	output logic mech_warmup_enable_io,
	output logic io_right,
	output logic motion_busy
);
	logic flip_q;
	logic right_q;
	logic en_q;
	logic busy_q;
	initial begin
		flip_q = 1'b0;
		right_q = 1'b0;
		en_q = 1'b0;
		busy_q = 1'b0;
		io_right = 1'b0;
		motion_busy = 1'b0;
		mech_warmup_enable_io = 1'b0;
	end
	// requests change at the falling edge, so they are taken at the rising one
	always @(posedge clk) begin
		right_q <= want_right;
		en_q <= want_en;
		busy_q <= want_busy;
	end
	always @(negedge clk) begin
		io_right <= right_q;
		motion_busy <= busy_q;
		flip_q <= !flip_q;
		// without the right the line is not ours: toggle so no stale level passes
		mech_warmup_enable_io <= right_q ? en_q : flip_q;
	end
endmodule
`default_nettype wire

// file: sim/wupc_monitor.sv
// wupc_monitor: port assertions of wupc_ctrl
// assumes cfg stays stable between resets
`timescale 1ns/1ps
`default_nettype none
module wupc_monitor
	import wupc_pkg::*;
#(
	parameter int unsigned NJ = 8,
	parameter int unsigned TICK_CYC = TICK_CYCLES
) (
	input wire logic clk,
	input wire logic nrst,
	input wire wupc_cfg_t cfg,
	input wire logic mech_warmup_enable_io,
	input wire logic io_right,
	input wire logic motion_busy,
	input wire logic panel_ovr_view,
	input wire logic mech_warmup_enable_out,
	input wire logic mech_warmup_active_out,
	input wire logic panel_underscore,
	input wire wupc_stat_t stat
);
	// ==========================================================
	// settle count: the power-on latch is not an input take
	logic [1:0] up_q;
	logic ok;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			up_q <= 2'h0;
		end else if (up_q != 2'h3) begin
			up_q <= up_q + 2'h1;
		end
	end
	assign ok = cfg.warmup_enable_param && cfg.target_joint_mask != 8'h00
		&& cfg.valid_min != 6'h00 && cfg.init_ovr < OVR_FULL;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// ==========================================================
	a_warm_slow: assert property (
		mech_warmup_active_out [*2] |-> stat.current_slowdown_value < OVR_FULL)
		else $error("override not reduced in warm-up");
	a_normal_full: assert property (
		!mech_warmup_active_out [*2] |-> stat.current_slowdown_value == OVR_FULL)
		else $error("override not full in normal state");
	a_mark_on: assert property (
		(mech_warmup_active_out && panel_ovr_view) [*2] |-> panel_underscore)
		else $error("panel marker missing");
	a_mark_off: assert property (
		!panel_ovr_view [*2] |=> !panel_underscore)
		else $error("panel marker without override view");
	a_right_held: assert property (
		(!io_right && up_q == 2'h3) |-> ##2 $stable(mech_warmup_enable_out))
		else $error("enable moved without the right");
	a_busy_held: assert property (
		(motion_busy && up_q == 2'h3) |-> ##2 $stable(mech_warmup_enable_out))
		else $error("enable moved during motion");
	a_enable_take: assert property (
		(io_right && !motion_busy && ok && up_q == 2'h3
		&& mech_warmup_enable_io != mech_warmup_enable_out)
		|-> ##2 mech_warmup_enable_out == $past(mech_warmup_enable_io, 2))
		else $error("enable input not taken");
	a_enable_warm: assert property (
		($rose(mech_warmup_enable_out) && up_q == 2'h3) |-> ##2 mech_warmup_active_out)
		else $error("enable did not enter warm-up");
	a_off_quiet: assert property (
		!mech_warmup_enable_out [*4] |-> !mech_warmup_active_out)
		else $error("warm-up while disabled");
endmodule
bind wupc_ctrl wupc_monitor #(.NJ(NJ), .TICK_CYC(TICK_CYC)) u_mon (
	.clk(clk), .nrst(nrst), .cfg(cfg), .mech_warmup_enable_io(mech_warmup_enable_io),
	.io_right(io_right), .motion_busy(motion_busy), .panel_ovr_view(panel_ovr_view),
	.mech_warmup_enable_out(mech_warmup_enable_out),
	.mech_warmup_active_out(mech_warmup_active_out),
	.panel_underscore(panel_underscore), .stat(stat));
`default_nettype wire

// file: sim/test_warmup_speed_state_control.sv
// test_warmup_speed_state_control: directed checks of wupc_ctrl
// assumes a 10-cycle second, so one minute is 600 cycles
`timescale 1ns/1ps
`default_nettype none
module test_warmup_speed_state_control;
	import wupc_pkg::*;
	localparam int unsigned TC = 10;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	wupc_cfg_t cfg = '{1'b1, 8'h03, 6'h01, 11'h001, 7'h46, 6'h32};
	logic [7:0] mv = 8'h00;
	logic wc = 1'b0;
	logic [SEC_W-1:0] off_s = 17'h00000;
	logic view = 1'b0;
	logic w_r = 1'b0;
	logic w_e = 1'b0;
	logic w_b = 1'b0;
	logic io_en, io_r, busy, en_o, act_o, und;
	wupc_stat_t stat;
	int miscompares = 0;
	int compares = 0;
	always #4 clk = ~clk;
	wupc_io_host host (.clk(clk), .want_right(w_r), .want_en(w_e), .want_busy(w_b),
		.mech_warmup_enable_io(io_en), .io_right(io_r), .motion_busy(busy));
	wupc_ctrl #(.NJ(8), .TICK_CYC(TC)) dut (.clk(clk), .nrst(nrst), .cfg(cfg),
		.joint_moving(mv), .was_cancelled(wc), .off_stop_sec(off_s),
		.mech_warmup_enable_io(io_en), .io_right(io_r), .motion_busy(busy),
		.panel_ovr_view(view), .mech_warmup_enable_out(en_o),
		.mech_warmup_active_out(act_o), .panel_underscore(und), .stat(stat));
	// ==========================================================
	task automatic conclude();
		if (miscompares == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [SEC_W-1:0] got, input logic [SEC_W-1:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic st(input logic e_en, input logic e_act, input logic [6:0] e_ovr);
		chk(SEC_W'(en_o), SEC_W'(e_en));
		chk(SEC_W'(act_o), SEC_W'(e_act));
		chk(SEC_W'(stat.current_slowdown_value), SEC_W'(e_ovr));
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic secs(input int n);
		cyc(n * TC);
	endtask
	task automatic io(input logic r, input logic e, input logic b);
		w_r = r;
		w_e = e;
		w_b = b;
		cyc(6);
	endtask
	// power cycle: cfg and carried stop time must be set while held
	task automatic boot(input logic [7:0] m, input logic [5:0] v, input logic [6:0] o,
		input logic c, input logic [SEC_W-1:0] off);
		@(negedge clk);
		nrst = 1'b0;
		cfg.target_joint_mask = m;
		cfg.valid_min = v;
		cfg.init_ovr = o;
		wc = c;
		off_s = off;
		cyc(3);
		nrst = 1'b1;
		cyc(6);
	endtask
	// ==========================================================
	initial begin
		boot(8'h00, 6'h01, 7'h46, 1'b0, 17'h00000);
		st(1'b0, 1'b0, OVR_FULL);
		boot(8'h03, 6'h00, 7'h46, 1'b0, 17'h00000);
		st(1'b0, 1'b0, OVR_FULL);
		boot(8'h03, 6'h01, OVR_FULL, 1'b0, 17'h00000);
		st(1'b0, 1'b0, OVR_FULL);
		boot(8'h03, 6'h01, 7'h46, 1'b1, 17'h0000a);
		st(1'b1, 1'b0, OVR_FULL);
		boot(8'h03, 6'h01, 7'h46, 1'b1, 17'h00046);
		st(1'b1, 1'b1, 7'h46);
		boot(8'h03, 6'h3f, 7'h28, 1'b0, 17'h00000);
		st(1'b1, 1'b1, OVR_MIN);
		chk(stat.remaining_run_time, 17'h00e10);
		boot(8'h03, 6'h01, 7'h46, 1'b0, 17'h00000);
		st(1'b1, 1'b1, 7'h46);
		chk(stat.remaining_run_time, 17'h0003c);
		view = 1'b1;
		cyc(3);
		chk(SEC_W'(und), 17'h00001);
		// joint two idle keeps the least run time at zero
		mv = 8'h01;
		secs(70);
		st(1'b1, 1'b1, 7'h46);
		mv = 8'h03;
		secs(45);
		chk(SEC_W'(stat.current_slowdown_value > 7'h46), 17'h00001);
		secs(20);
		st(1'b1, 1'b0, OVR_FULL);
		chk(SEC_W'(und), 17'h00000);
		chk(stat.remaining_stop_time, 17'h0003c);
		mv = 8'h01;
		secs(55);
		st(1'b1, 1'b0, OVR_FULL);
		secs(10);
		st(1'b1, 1'b1, 7'h46);
		io(1'b1, 1'b0, 1'b1);
		st(1'b1, 1'b1, 7'h46);
		io(1'b0, 1'b0, 1'b0);
		st(1'b1, 1'b1, 7'h46);
		io(1'b1, 1'b0, 1'b0);
		st(1'b0, 1'b0, OVR_FULL);
		io(1'b0, 1'b1, 1'b0);
		st(1'b0, 1'b0, OVR_FULL);
		// a short carried stop would pick normal unless the take forces warm-up
		wc = 1'b1;
		io(1'b1, 1'b1, 1'b0);
		st(1'b1, 1'b1, 7'h46);
		cfg.warmup_enable_param = 1'b0;
		cyc(4);
		chk(SEC_W'(en_o), 17'h00001);
		boot(8'h03, 6'h01, 7'h46, 1'b0, 17'h00000);
		st(1'b0, 1'b0, OVR_FULL);
		io(1'b1, 1'b0, 1'b0);
		io(1'b1, 1'b1, 1'b0);
		st(1'b0, 1'b0, OVR_FULL);
		conclude();
	end
	// whole run is near 2130 cycles; allow about twelve times that
	initial begin
		repeat (26000) @(posedge clk);
		miscompares++;
		conclude();
	end
endmodule
`default_nettype wire
